/* logic/sps_top.sv */
`timescale 1ns/1ps
// Functional notes
// (RULE_01) eight edge flip-flops form one 8-bit register with stage and shift gating
// (RULE_02) contents change only on a rising clk edge, clearing aside
// (RULE_03) clear_n low clears all bits and ser_out at once, ignoring everything
// (RULE_04) op_allow_n high holds; low makes the edge shift or load
// (RULE_05) select high shifts right; low loads and turns bus drivers off
// (RULE_06) shift with sign_ext_n high: top bit takes input a or b by entry_pick
// (RULE_07) shift with sign_ext_n low: top bit keeps its value, copying the sign
// (RULE_08) bus_drive_n high floats every par_bus pin whatever else is set
// (RULE_09) floating the bus blocks neither shift, load nor clear
// (RULE_10) load edge captures each par_bus pin; register isolated from pins meanwhile
// (RULE_11) ser_out always driven from bit 0, unaffected by bus disables
// (RULE_12) shift moves each bit n from n+1, ser_out then shows old bit 1
// (RULE_13) one shared set of eight pins is both load input and output
// (RULE_14) outside master drives valid par_bus data around each load edge
module sps_top (
  // clock, bus reset and register clear
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_CLEAR_N,
  // mode controls
  input wire logic I_OP_ALLOW_N,
  input wire logic I_SHIFT_OR_LOAD_SEL,
  input wire logic I_SIGN_EXT_N,
  input wire logic I_ENTRY_PICK,
  input wire logic I_BUS_DRIVE_N,
  // serial side
  input wire logic I_SER_IN_A,
  input wire logic I_SER_IN_B,
  output logic O_SER_OUT,
  output logic O_TOP_BIT,
  // shared parallel pins
  input wire logic [7:0] I_PAR_BUS,
  output logic [7:0] O_PAR_BUS,
  output logic [7:0] O_PAR_BUS_OE,
  // avalon-mm register bus
  input wire logic [3:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST
);
  sps_ctl_if ctl ();

  logic oe_q;
  logic oe_d;
  logic load_sel;
  logic par_oe;

  // the load edge reads the same pins that otherwise carry the register
  sps_shift_core u_core (
    .i_clk(I_CLK),
    .i_clear_n(I_CLEAR_N),
    .i_op_allow_n(I_OP_ALLOW_N),
    .i_shift_or_load_sel(I_SHIFT_OR_LOAD_SEL),
    .i_sign_ext_n(I_SIGN_EXT_N),
    .i_entry_pick(I_ENTRY_PICK),
    .i_ser_in_a(I_SER_IN_A),
    .i_ser_in_b(I_SER_IN_B),
    .i_par_in(I_PAR_BUS), // see (RULE_13) (RULE_14)
    .ctl(ctl.core)
  );

  sps_avmm_slave u_bus (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_address(I_AVS_ADDRESS),
    .i_read(I_AVS_READ),
    .i_write(I_AVS_WRITE),
    .i_byteenable(I_AVS_BYTEENABLE),
    .i_writedata(I_AVS_WRITEDATA),
    .o_readdata(O_AVS_READDATA),
    .o_waitrequest(O_AVS_WAITREQUEST),
    .i_ser_out(ctl.value[0]),
    .ctl(ctl.bus)
  );

  assign load_sel = !I_OP_ALLOW_N && !I_SHIFT_OR_LOAD_SEL;

  // software enable is registered; the pin controls gate it at once, so the
  // pins float in the very cycle that bus_drive_n or a load asks for it
  always_comb begin
    oe_d = !ctl.drive_dis;
  end

  always_comb begin
    if (I_BUS_DRIVE_N) begin
      par_oe = 1'b0; // see (RULE_08) (RULE_09)
    end else if (load_sel) begin
      par_oe = 1'b0; // see (RULE_05) (RULE_10)
    end else begin
      par_oe = oe_q;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= oe_d;
    end
  end

  assign ctl.par_oe = par_oe;
  assign O_PAR_BUS = ctl.value; // see (RULE_13)
  assign O_PAR_BUS_OE = {sps_pkg::WIDTH{par_oe}};
  assign O_SER_OUT = ctl.value[0]; // see (RULE_11)
  assign O_TOP_BIT = ctl.value[sps_pkg::MSB];

  a_float_on_drive_n: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // see (RULE_08)
    I_BUS_DRIVE_N |-> O_PAR_BUS_OE == 8'h00)
    else $error("par_bus driven while bus_drive_n high");

  a_float_on_load: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // see (RULE_05)
    load_sel |-> O_PAR_BUS_OE == 8'h00)
    else $error("par_bus driven during load");

  a_shift_while_float: assert property (@(posedge I_CLK) disable iff (!I_CLEAR_N) // see (RULE_09)
    (I_BUS_DRIVE_N && !I_OP_ALLOW_N && I_SHIFT_OR_LOAD_SEL)
      |=> O_SER_OUT == $past(ctl.value[1]))
    else $error("shift blocked while outputs float");

  a_ser_out_bit0: assert property (@(posedge I_CLK) // see (RULE_11)
    (O_SER_OUT == O_PAR_BUS[0]) and (!I_CLEAR_N |-> !O_SER_OUT))
    else $error("ser_out does not follow bit 0");
endmodule

/* logic/sps_pkg.sv */
package sps_pkg;
  // register width
  localparam int unsigned WIDTH = 8;
  localparam int unsigned MSB = WIDTH - 1;
  localparam logic [WIDTH-1:0] REG_RESET = 8'h00;
  // bus map, byte addresses
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
  // control register fields
  localparam int unsigned CTRL_DRIVE_DIS_BIT = 0;
  localparam logic CTRL_DRIVE_DIS_RESET = 1'b0;
  // status register fields
  localparam int unsigned STATUS_VALUE_LSB = 0;
  localparam int unsigned STATUS_SER_OUT_BIT = 8;
  localparam int unsigned STATUS_OE_BIT = 9;
  localparam logic [31:0] RDATA_NONE = 32'h0000_0000;
  // bus answer state
  typedef enum logic [1:0] {
    SPS_BUS_IDLE = 2'b01,
    SPS_BUS_ACK = 2'b10
  } sps_bus_state_t;
endpackage

/* logic/sps_ctl_if.sv */
`timescale 1ns/1ps
interface sps_ctl_if;
  logic [7:0] value;
  logic drive_dis;
  logic par_oe;
  modport core (output value, input drive_dis, input par_oe);
  modport bus (input value, output drive_dis, input par_oe);
endinterface

/* logic/sps_shift_core.sv */
`timescale 1ns/1ps
module sps_shift_core (
  // clock and clear
  input wire logic i_clk,
  input wire logic i_clear_n,
  // mode controls
  input wire logic i_op_allow_n,
  input wire logic i_shift_or_load_sel,
  input wire logic i_sign_ext_n,
  input wire logic i_entry_pick,
  // data inputs
  input wire logic i_ser_in_a,
  input wire logic i_ser_in_b,
  input wire logic [7:0] i_par_in,
  // register state out
  sps_ctl_if.core ctl
);
  logic [7:0] bits_q;
  logic [7:0] bits_d;
  logic top_bit_entry;

  // serial entry for the top bit: own value under sign extension
  always_comb begin
    if (!i_sign_ext_n) begin
      top_bit_entry = bits_q[sps_pkg::MSB]; // see (RULE_07)
    end else if (i_entry_pick) begin
      top_bit_entry = i_ser_in_b; // see (RULE_06)
    end else begin
      top_bit_entry = i_ser_in_a; // see (RULE_06)
    end
  end

  // per-stage gating: hold, shift, load
  genvar n;
  generate
    for (n = 0; n < sps_pkg::WIDTH; n++) begin : g_stage
      logic shift_src;
      if (n == sps_pkg::MSB) begin : g_top
        assign shift_src = top_bit_entry;
      end else begin : g_low
        assign shift_src = bits_q[n+1]; // see (RULE_12)
      end
      always_comb begin
        if (i_op_allow_n) begin
          bits_d[n] = bits_q[n]; // see (RULE_04)
        end else if (i_shift_or_load_sel) begin
          bits_d[n] = shift_src; // see (RULE_05)
        end else begin
          bits_d[n] = i_par_in[n]; // see (RULE_10)
        end
      end
    end
  endgenerate

  // eight edge flip-flops, cleared at once by clear_n
  always_ff @(posedge i_clk or negedge i_clear_n) begin // see (RULE_01) (RULE_02)
    if (!i_clear_n) begin
      bits_q <= sps_pkg::REG_RESET; // see (RULE_03)
    end else begin
      bits_q <= bits_d;
    end
  end

  assign ctl.value = bits_q;

  a_hold_keeps: assert property (@(posedge i_clk) disable iff (!i_clear_n) // see (RULE_04)
    i_op_allow_n |=> bits_q == $past(bits_q))
    else $error("hold changed the register");

  a_shift_moves_right: assert property (@(posedge i_clk) disable iff (!i_clear_n) // see (RULE_12)
    (!i_op_allow_n && i_shift_or_load_sel) |=> bits_q[6:0] == $past(bits_q[7:1]))
    else $error("shift did not move bits right");

  a_entry_mux_top: assert property (@(posedge i_clk) disable iff (!i_clear_n) // see (RULE_06)
    (!i_op_allow_n && i_shift_or_load_sel && i_sign_ext_n)
      |=> bits_q[7] == ($past(i_entry_pick) ? $past(i_ser_in_b) : $past(i_ser_in_a)))
    else $error("top bit took wrong serial input");

  a_sign_ext_top: assert property (@(posedge i_clk) disable iff (!i_clear_n) // see (RULE_07)
    (!i_op_allow_n && i_shift_or_load_sel && !i_sign_ext_n)
      |=> bits_q[7] == $past(bits_q[7]) && bits_q[6] == $past(bits_q[7]))
    else $error("sign extension lost the sign bit");

  a_load_captures: assert property (@(posedge i_clk) disable iff (!i_clear_n) // see (RULE_10)
    (!i_op_allow_n && !i_shift_or_load_sel) |=> bits_q == $past(i_par_in))
    else $error("load did not capture parallel input");

  a_clear_zero: assert property (@(posedge i_clk) // see (RULE_03)
    !i_clear_n |-> bits_q == sps_pkg::REG_RESET)
    else $error("register not clear while clear_n low");
endmodule

/* logic/sps_avmm_slave.sv */
`timescale 1ns/1ps
module sps_avmm_slave (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // avalon-mm slave
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // ser_out copy for status
  input wire logic i_ser_out,
  // block side
  sps_ctl_if.bus ctl
);
  sps_pkg::sps_bus_state_t state_q;
  sps_pkg::sps_bus_state_t state_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic drive_dis_q;
  logic drive_dis_d;
  logic accept;

  function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
    hit = (addr == ofs);
  endfunction

  // request is taken at the edge where waitrequest is low
  assign accept = (state_q == sps_pkg::SPS_BUS_ACK) && (i_read || i_write);

  always_comb begin
    state_d = state_q;
    rdata_d = rdata_q;
    drive_dis_d = drive_dis_q;
    case (state_q)
      sps_pkg::SPS_BUS_IDLE: begin
        if (i_read || i_write) begin
          state_d = sps_pkg::SPS_BUS_ACK;
          rdata_d = sps_pkg::RDATA_NONE;
          if (i_read && hit(i_address, sps_pkg::OFS_CTRL)) begin
            rdata_d[sps_pkg::CTRL_DRIVE_DIS_BIT] = drive_dis_q;
          end else if (i_read && hit(i_address, sps_pkg::OFS_STATUS)) begin
            rdata_d[sps_pkg::STATUS_VALUE_LSB +: 8] = ctl.value;
            rdata_d[sps_pkg::STATUS_SER_OUT_BIT] = i_ser_out;
            rdata_d[sps_pkg::STATUS_OE_BIT] = ctl.par_oe;
          end
        end
      end
      sps_pkg::SPS_BUS_ACK: begin
        state_d = sps_pkg::SPS_BUS_IDLE;
        if (accept && i_write && hit(i_address, sps_pkg::OFS_CTRL) && i_byteenable[0]) begin
          drive_dis_d = i_writedata[sps_pkg::CTRL_DRIVE_DIS_BIT];
        end
      end
      default: begin
        state_d = sps_pkg::SPS_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_q <= sps_pkg::SPS_BUS_IDLE;
      rdata_q <= sps_pkg::RDATA_NONE;
      drive_dis_q <= sps_pkg::CTRL_DRIVE_DIS_RESET;
    end else begin
      state_q <= state_d;
      rdata_q <= rdata_d;
      drive_dis_q <= drive_dis_d;
    end
  end

  assign o_waitrequest = (state_q != sps_pkg::SPS_BUS_ACK);
  assign o_readdata = rdata_q;
  assign ctl.drive_dis = drive_dis_q;

  a_wait_one_cycle: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !o_waitrequest |=> o_waitrequest)
    else $error("waitrequest low for more than one cycle");
endmodule

/* dv/sps_bus_partner.sv */
`timescale 1ns/1ps
module sps_bus_partner (
  // pin side
  input wire logic i_clk,
  input wire logic [7:0] i_dev_data,
  input wire logic [7:0] i_dev_oe,
  input wire logic i_drv_en,
  input wire logic [7:0] i_drv_data,
  output logic [7:0] o_pin
);
  logic [7:0] last_q;
  always_ff @(posedge i_clk) begin
    last_q <= o_pin;
  end
  // released pins show i_drv_data under i_drv_en, else the inverse of the last level, not a kind constant
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      o_pin[i] = i_dev_oe[i] ? i_dev_data[i] : (i_drv_en ? i_drv_data[i] : ~last_q[i]);
    end
  end
endmodule

/* dv/tb_sps_top.sv */
`timescale 1ns/1ps
module tb_sps_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic clr_n, allow_n, sel, se_n, pick, drv_n, sa, sb;
  logic ser_out, top_bit, rd, wr, wait_r, ctrl_dis;
  logic [7:0] pdata, pin, dev_q, dev_oe, exp_q;
  logic [3:0] addr, be;
  logic [31:0] wdata, rdata, q;
  logic [7:0] dir [6] = '{8'b1000_0100, 8'b1010_0100, 8'b1010_0100, 8'b1011_0110,
    8'b1011_1101, 8'b0011_0111};
  int failures = 0;
  int total_checks = 0;
  int seed;
  always #2 clk = ~clk;
  sps_top i_sps_top (
    .I_CLK(clk),
    .I_RSTN(rstn),
    .I_CLEAR_N(clr_n),
    .I_OP_ALLOW_N(allow_n),
    .I_SHIFT_OR_LOAD_SEL(sel),
    .I_SIGN_EXT_N(se_n),
    .I_ENTRY_PICK(pick),
    .I_BUS_DRIVE_N(drv_n),
    .I_SER_IN_A(sa),
    .I_SER_IN_B(sb),
    .O_SER_OUT(ser_out),
    .O_TOP_BIT(top_bit),
    .I_PAR_BUS(pin),
    .O_PAR_BUS(dev_q),
    .O_PAR_BUS_OE(dev_oe),
    .I_AVS_ADDRESS(addr),
    .I_AVS_READ(rd),
    .I_AVS_WRITE(wr),
    .I_AVS_BYTEENABLE(be),
    .I_AVS_WRITEDATA(wdata),
    .O_AVS_READDATA(rdata),
    .O_AVS_WAITREQUEST(wait_r)
  );
  sps_bus_partner i_sps_bus_partner (
    .i_clk(clk),
    .i_dev_data(dev_q),
    .i_dev_oe(dev_oe),
    .i_drv_en(1'b1),
    .i_drv_data(pdata),
    .o_pin(pin)
  );
  // expected register after one edge, from the levels standing before it
  function automatic logic [7:0] ref_next(input logic [7:0] cur, input logic [7:0] p);
    if (!clr_n) return 8'h00;
    if (allow_n) return cur;
    if (!sel) return p;
    return {se_n ? (pick ? sb : sa) : cur[7], cur[7:1]};
  endfunction
  // expected driver enable for the controls now standing
  function automatic logic ref_oe();
    return rstn & ~(drv_n | (~allow_n & ~sel) | ctrl_dis);
  endfunction
  always @(posedge clk) begin
    exp_q <= ref_next(exp_q, pin);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // controls packed as clear, allow, select, sign, pick, drive, entry a, entry b
  task automatic step(input logic [7:0] c, input logic [7:0] dat);
    @(posedge clk);
    {clr_n, allow_n, sel, se_n, pick, drv_n, sa, sb} <= c;
    pdata <= dat;
    @(negedge clk);
    check(32'(dev_q), 32'(clr_n ? exp_q : 8'h00));
    check(32'({ser_out, top_bit}), 32'(clr_n ? {exp_q[0], exp_q[7]} : 2'b00));
    check(32'(dev_oe), 32'({8{ref_oe()}}));
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] b,
    input logic [31:0] d, output logic [31:0] r);
    int n = 0;
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    be <= b;
    wdata <= d;
    // request stands until the edge that samples waitrequest low
    do begin
      @(posedge clk);
      n++;
    end while (wait_r !== 1'b0 && n < 20);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wait_r !== 1'b0) begin
      failures++;
      print_verdict();
    end
  endtask
  initial begin
    logic [7:0] c;
    seed = 32'h7d9c;
    ctrl_dis = 1'b0;
    {clr_n, allow_n, sel, se_n, pick, drv_n, sa, sb} <= 8'b0100_0100;
    {rd, wr, addr, be, wdata, pdata} <= '0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++) step(dir[i], 8'h96);
    $display("directed modes done");
    for (int i = 0; i < 400; i++) begin
      c = 8'($random(seed));
      c[7] = c[7] | c[6] | c[5];
      step(c, 8'($random(seed)));
    end
    $display("random modes done");
    step(8'b1100_0000, 8'h00);
    step(8'b1100_0000, 8'h00);
    bus(1'b0, sps_pkg::OFS_CTRL, 4'hf, 32'h0, q);
    check(q, 32'h0);
    bus(1'b0, sps_pkg::OFS_STATUS, 4'hf, 32'h0, q);
    check(q, {22'h0, ref_oe(), exp_q[0], exp_q});
    bus(1'b1, sps_pkg::OFS_STATUS, 4'hf, 32'hffff_ffff, q);
    bus(1'b1, sps_pkg::OFS_CTRL, 4'h0, 32'h1, q);
    bus(1'b0, sps_pkg::OFS_CTRL, 4'hf, 32'h0, q);
    check(q, 32'h0);
    bus(1'b1, sps_pkg::OFS_CTRL, 4'h1, 32'h1, q);
    ctrl_dis = 1'b1;
    bus(1'b0, 4'hc, 4'hf, 32'h0, q);
    check(q, 32'h0);
    bus(1'b0, sps_pkg::OFS_CTRL, 4'hf, 32'h0, q);
    check(q, 32'h1);
    for (int i = 0; i < 30; i++) step(8'($random(seed)) | 8'h80, 8'($random(seed)));
    bus(1'b1, sps_pkg::OFS_CTRL, 4'h1, 32'h0, q);
    ctrl_dis = 1'b0;
    bus(1'b0, sps_pkg::OFS_CTRL, 4'hf, 32'h0, q);
    check(q, 32'h0);
    $display("register bus done");
    print_verdict();
  end
endmodule
